// ===== ast_uart_core.v
// frame-level asynchronous serial transmitter and receiver with its registers
//
// What this block does
// - words of 8 or 9 bits by select
// - break ends with configured high stop bits
// - one baud generator, gated per direction enable
// - lsb first; holding register before shifter
// - start low; 0.5/1/1.5/2 stop bits
// - transmit disable freezes counters, frame lost
// - transmit enable first sends idle frame
// - break is 10 or 11 low bits
// - held data write clears empty; load sets it
// - busy write held; idle write loads directly
// - frame end with empty holding sets finished
// - finished clears by status-read-then-write or zero
// - break after current char; request auto-clears
// - withdrawn request sends no break
// - one start pattern at the single 16-tick oversampling rate
// - incomplete start pattern aborts without flags
// - start triples decide clean, noisy or abort
// - receive enable starts start-bit search
// - character end fills holding, sets full
// - full clears on data read or zero
// - receive disable abandons current character
// - enabled idle transmitter holds line high
// - overrun keeps older holding content
//
// The implementer's own choices: the strobed register port and the address map.
`include "ast_uart_map.vh"

module ast_uart_core #(
  parameter BAUD_W = 16
) (
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  input  wire [`AST_ADDR_W-1:0] addr_in,
  input  wire [15:0]           wr_data_in,
  input  wire                  wr_in,
  input  wire                  rd_in,
  output reg  [15:0]           rd_data_out,
  input  wire                  rx_line_in,
  output reg                   tx_line_out,
  output reg                   tx_line_oe_out
);

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [2:0] T_IDLE  = 3'h0;
  localparam [2:0] T_PRE   = 3'h1;
  localparam [2:0] T_START = 3'h2;
  localparam [2:0] T_DATA  = 3'h3;
  localparam [2:0] T_STOP  = 3'h4;
  localparam [2:0] T_BRK   = 3'h5;
  localparam [1:0] R_IDLE  = 2'h0;
  localparam [1:0] R_START = 2'h1;
  localparam [1:0] R_DATA  = 2'h2;
  localparam [1:0] R_STOP  = 2'h3;

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  reg  [15:0]       ctrl1_q;
  reg  [15:0]       ctrl2_q;
  reg  [BAUD_W-1:0] baud_q;
  reg               sr_seen_q;
  reg  [2:0]        tst_q;
  reg               te_q;
  reg  [8:0]        thold_q;
  reg  [8:0]        tsh_q;
  reg  [3:0]        tsub_q;
  reg  [3:0]        tbit_q;
  reg  [5:0]        tstop_q;
  reg               tx_holding_empty_q;
  reg               tx_finished_q;
  reg               send_break_request_q;
  reg  [1:0]        rst_q;
  reg  [4:0]        rsub_q;
  reg  [3:0]        rbit_q;
  reg  [1:0]        hist_q;
  reg  [1:0]        cap_q;
  reg  [8:0]        rsh_q;
  reg               noise_acc_q;
  reg  [8:0]        rx_holding_reg_q;
  reg               rx_holding_full_q;
  reg               noise_flag_q;
  reg               overrun_flag_q;
  reg               frame_flag_q;
  reg  [5:0]        stop_ticks;
  reg  [15:0]       status_word;

  wire              unit_on    = ctrl1_q[`AST_CR1_UE];
  wire              word9      = ctrl1_q[`AST_CR1_M];
  wire              tx_path_on = unit_on & ctrl1_q[`AST_CR1_TE];
  wire              rx_path_on = unit_on & ctrl1_q[`AST_CR1_RE];
  wire              wr_data    = wr_in && (addr_in == `AST_OFS_DATA);
  wire              wr_stat    = wr_in && (addr_in == `AST_OFS_STATUS);
  wire              rd_data    = rd_in && (addr_in == `AST_OFS_DATA);
  wire              rd_stat    = rd_in && (addr_in == `AST_OFS_STATUS);
  wire [3:0]        nbits_m1   = word9 ? 4'h8 : 4'h7;
  wire              base_tick;
  wire              tx_tick    = base_tick & tx_path_on;
  wire              rx_tick    = base_tick & rx_path_on;
  wire              vote_val;
  wire              vote_noisy;

  // ----------------------------------------------------------------
  // shared baud generator and the sample voter
  // ----------------------------------------------------------------
  ast_baud #(
    .W (BAUD_W)
  ) u_baud (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (tx_path_on | rx_path_on),
    .div_in     (baud_q),
    .tick_out   (base_tick)
  );

  ast_vote3 u_vote (
    .smp_in    ({cap_q[1], cap_q[0], rx_line_in}),
    .val_out   (vote_val),
    .noisy_out (vote_noisy)
  );

  // ----------------------------------------------------------------
  // configuration registers and read port
  // ----------------------------------------------------------------
  // stop length in oversample ticks, less one
  always @* begin
    case (ctrl2_q[`AST_CR2_STOP_MSB:`AST_CR2_STOP_LSB])
      `AST_STOP_HALF: stop_ticks = `AST_STOP_T_HALF;
      `AST_STOP_2:    stop_ticks = `AST_STOP_T_2;
      `AST_STOP_1P5:  stop_ticks = `AST_STOP_T_1P5;
      default:        stop_ticks = `AST_STOP_T_1;
    endcase
  end

  always @* begin
    status_word                = 16'h0000;
    status_word[`AST_SR_FRAME] = frame_flag_q;
    status_word[`AST_SR_NOISE] = noise_flag_q;
    status_word[`AST_SR_OVR]   = overrun_flag_q;
    status_word[`AST_SR_RXF]   = rx_holding_full_q;
    status_word[`AST_SR_TXF]   = tx_finished_q;
    status_word[`AST_SR_TXE]   = tx_holding_empty_q;
  end

  // the break request bit of ctrl1 lives in the transmitter process
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl1_q     <= `AST_CTRL1_RST;
      ctrl2_q     <= `AST_CTRL2_RST;
      baud_q      <= `AST_BAUD_RST;
      sr_seen_q   <= 1'b0;
      rd_data_out <= 16'h0000;
    end else begin
      if (wr_in && addr_in == `AST_OFS_CTRL1)
        ctrl1_q <= wr_data_in;
      if (wr_in && addr_in == `AST_OFS_CTRL2)
        ctrl2_q <= wr_data_in;
      if (wr_in && addr_in == `AST_OFS_BAUD)
        baud_q <= wr_data_in[BAUD_W-1:0];
      // status read arms the two-step clear of the next data access
      if (rd_stat)
        sr_seen_q <= 1'b1;
      else if (rd_data || wr_data)
        sr_seen_q <= 1'b0;
      if (rd_in) begin
        case (addr_in)
          `AST_OFS_STATUS: rd_data_out <= status_word;
          `AST_OFS_DATA:   rd_data_out <= {7'h00, rx_holding_reg_q};
          `AST_OFS_CTRL1:  rd_data_out <= {ctrl1_q[15:1], send_break_request_q};
          `AST_OFS_CTRL2:  rd_data_out <= ctrl2_q;
          `AST_OFS_BAUD:   rd_data_out <= baud_q;
          default:         rd_data_out <= 16'h0000;
        endcase
      end else begin
        rd_data_out <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      tst_q                <= T_IDLE;
      te_q                 <= 1'b0;
      thold_q              <= 9'h000;
      tsh_q                <= 9'h000;
      tsub_q               <= 4'h0;
      tbit_q               <= 4'h0;
      tstop_q              <= 6'h00;
      tx_holding_empty_q   <= 1'b1;
      tx_finished_q        <= 1'b1;
      send_break_request_q <= 1'b0;
      tx_line_out          <= 1'b1;
      tx_line_oe_out       <= 1'b0;
    end else begin
      te_q <= tx_path_on;
      // clears come first so a frame end in the same cycle still sets
      if (wr_data && sr_seen_q)
        tx_finished_q <= 1'b0;
      if (wr_stat && !wr_data_in[`AST_SR_TXF])
        tx_finished_q <= 1'b0;
      if (!tx_path_on) begin
        // counters freeze; the frame in progress is abandoned
        tx_line_oe_out <= 1'b0;
        tx_line_out    <= 1'b1;
      end else if (!te_q) begin
        tst_q          <= T_PRE;
        tsub_q         <= 4'h0;
        tbit_q         <= 4'h0;
        tx_line_oe_out <= 1'b1;
        tx_line_out    <= 1'b1;
      end else begin
        case (tst_q)
          T_IDLE: begin
            tx_line_out <= 1'b1;
            tsub_q      <= 4'h0;
            tbit_q      <= 4'h0;
            if (send_break_request_q) begin
              tst_q       <= T_BRK;
              tx_line_out <= 1'b0;
            end else if (!tx_holding_empty_q) begin
              tsh_q              <= thold_q;
              tx_holding_empty_q <= 1'b1;
              tst_q              <= T_START;
              tx_line_out        <= 1'b0;
            end else if (wr_data) begin
              tsh_q       <= wr_data_in[8:0];
              tst_q       <= T_START;
              tx_line_out <= 1'b0;
            end
          end
          T_PRE: begin
            if (tx_tick) begin
              tsub_q <= tsub_q + 4'h1;
              if (tsub_q == `AST_OVS_LAST) begin
                tbit_q <= tbit_q + 4'h1;
                // start plus data slots all high, then the stop bits
                if (tbit_q == nbits_m1 + 4'h1) begin
                  tst_q   <= T_STOP;
                  tstop_q <= stop_ticks;
                end
              end
            end
          end
          T_START, T_DATA: begin
            if (tx_tick) begin
              tsub_q <= tsub_q + 4'h1;
              if (tsub_q == `AST_OVS_LAST) begin
                if (tst_q == T_DATA && tbit_q == nbits_m1) begin
                  tst_q       <= T_STOP;
                  tstop_q     <= stop_ticks;
                  tx_line_out <= 1'b1;
                end else begin
                  if (tst_q == T_DATA)
                    tbit_q <= tbit_q + 4'h1;
                  tst_q       <= T_DATA;
                  tx_line_out <= tsh_q[0];
                  tsh_q       <= {1'b0, tsh_q[8:1]};
                end
              end
            end
          end
          T_BRK: begin
            if (tx_tick) begin
              tsub_q <= tsub_q + 4'h1;
              if (tsub_q == `AST_OVS_LAST) begin
                tbit_q <= tbit_q + 4'h1;
                if (tbit_q == nbits_m1 + 4'h2) begin
                  tst_q                <= T_STOP;
                  tstop_q              <= stop_ticks;
                  tx_line_out          <= 1'b1;
                  send_break_request_q <= 1'b0;
                end
              end
            end
          end
          T_STOP: begin
            tx_line_out <= 1'b1;
            if (tx_tick) begin
              tstop_q <= tstop_q - 6'h01;
              if (tstop_q == 6'h00) begin
                tsub_q <= 4'h0;
                tbit_q <= 4'h0;
                if (!tx_holding_empty_q) begin
                  tsh_q              <= thold_q;
                  tx_holding_empty_q <= 1'b1;
                  tst_q              <= T_START;
                  tx_line_out        <= 1'b0;
                end else begin
                  tx_finished_q <= 1'b1;
                  tst_q         <= T_IDLE;
                end
              end
            end
          end
          default: tst_q <= T_IDLE;
        endcase
      end
      // a write after a load in the same cycle leaves the new word pending
      if (wr_data && !(tx_path_on && te_q && tst_q == T_IDLE && tx_holding_empty_q
                       && !send_break_request_q)) begin
        thold_q            <= wr_data_in[8:0];
        tx_holding_empty_q <= 1'b0;
      end
      if (wr_in && addr_in == `AST_OFS_CTRL1)
        send_break_request_q <= wr_data_in[`AST_CR1_SBK];
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rst_q             <= R_IDLE;
      rsub_q            <= 5'h00;
      rbit_q            <= 4'h0;
      hist_q            <= 2'h0;
      cap_q             <= 2'h0;
      rsh_q             <= 9'h000;
      noise_acc_q       <= 1'b0;
      rx_holding_reg_q  <= 9'h000;
      rx_holding_full_q <= 1'b0;
      noise_flag_q      <= 1'b0;
      overrun_flag_q    <= 1'b0;
      frame_flag_q      <= 1'b0;
    end else begin
      // clears first so a character ending now still raises its flags
      if (rd_data)
        rx_holding_full_q <= 1'b0;
      if (wr_stat && !wr_data_in[`AST_SR_RXF])
        rx_holding_full_q <= 1'b0;
      if (rd_data && sr_seen_q) begin
        noise_flag_q   <= 1'b0;
        overrun_flag_q <= 1'b0;
        frame_flag_q   <= 1'b0;
      end
      if (!rx_path_on) begin
        rst_q  <= R_IDLE;
        hist_q <= 2'h0;
      end else if (rx_tick) begin
        hist_q <= {hist_q[0], rx_line_in};
        rsub_q <= (rsub_q == `AST_SMP_LAST) ? 5'h01 : rsub_q + 5'h01;
        case (rst_q)
          R_IDLE: begin
            // two high samples then a low one is the falling edge
            if (hist_q == 2'h3 && !rx_line_in) begin
              rst_q       <= R_START;
              rsub_q      <= `AST_SMP_FIRST;
              noise_acc_q <= 1'b0;
            end
          end
          R_START: begin
            if (rsub_q == `AST_SMP_A || rsub_q == `AST_SMP_D)
              cap_q[0] <= rx_line_in;
            if (rsub_q == `AST_SMP_B || rsub_q == `AST_SMP_E)
              cap_q[1] <= rx_line_in;
            if (rsub_q == `AST_SMP_C || rsub_q == `AST_SMP_F) begin
              if (vote_val)
                rst_q <= R_IDLE;
              else
                noise_acc_q <= noise_acc_q | vote_noisy;
            end
            if (rsub_q == `AST_SMP_LAST) begin
              rst_q  <= R_DATA;
              rbit_q <= 4'h0;
            end
          end
          R_DATA, R_STOP: begin
            if (rsub_q == `AST_SMP_D)
              cap_q[0] <= rx_line_in;
            if (rsub_q == `AST_SMP_E)
              cap_q[1] <= rx_line_in;
            if (rsub_q == `AST_SMP_F) begin
              noise_acc_q <= noise_acc_q | vote_noisy;
              if (rst_q == R_DATA)
                rsh_q <= {vote_val, rsh_q[8:1]};
              else if (!vote_val && !rx_holding_full_q)
                frame_flag_q <= 1'b1;
            end
            if (rsub_q == `AST_SMP_LAST) begin
              if (rst_q == R_DATA) begin
                rbit_q <= rbit_q + 4'h1;
                if (rbit_q == nbits_m1)
                  rst_q <= R_STOP;
              end else begin
                // only the first stop bit is checked; the next edge search starts now
                rst_q <= R_IDLE;
                if (rx_holding_full_q) begin
                  overrun_flag_q <= 1'b1;
                end else begin
                  rx_holding_reg_q  <= word9 ? rsh_q : {1'b0, rsh_q[8:1]};
                  rx_holding_full_q <= 1'b1;
                  noise_flag_q      <= noise_acc_q | (noise_flag_q & !(rd_data && sr_seen_q));
                end
              end
            end
          end
          default: rst_q <= R_IDLE;
        endcase
      end
    end
  end

endmodule

// ===== ast_uart_map.vh
// address map, field positions, reset values and timing counts of the serial core
`ifndef AST_UART_MAP_VH
`define AST_UART_MAP_VH

// ----------------------------------------------------------------
// register indexes on the plain register port
// ----------------------------------------------------------------
`define AST_ADDR_W        3
`define AST_OFS_STATUS    3'h0
`define AST_OFS_DATA      3'h1
`define AST_OFS_CTRL1     3'h2
`define AST_OFS_CTRL2     3'h3
`define AST_OFS_BAUD      3'h4

// ----------------------------------------------------------------
// status_port bits
// ----------------------------------------------------------------
`define AST_SR_FRAME      1
`define AST_SR_NOISE      2
`define AST_SR_OVR        3
`define AST_SR_RXF        5
`define AST_SR_TXF        6
`define AST_SR_TXE        7

// ----------------------------------------------------------------
// control register 1 bits
// ----------------------------------------------------------------
`define AST_CR1_SBK       0
`define AST_CR1_RE        2
`define AST_CR1_TE        3
`define AST_CR1_RX_FULL_IRQ_ON    5
`define AST_CR1_TX_DONE_IRQ_ON      6
`define AST_CR1_TX_EMPTY_IRQ_ON     7
`define AST_CR1_M         12
`define AST_CR1_UE        13

// ----------------------------------------------------------------
// control register 2 stop field and its codes
// ----------------------------------------------------------------
`define AST_CR2_STOP_LSB  12
`define AST_CR2_STOP_MSB  13
`define AST_STOP_1        2'h0
`define AST_STOP_HALF     2'h1
`define AST_STOP_2        2'h2
`define AST_STOP_1P5      2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AST_CTRL1_RST     16'h0000
`define AST_CTRL2_RST     16'h0000
`define AST_BAUD_RST      16'h0010

// ----------------------------------------------------------------
// oversampling and sample positions within one bit
// ----------------------------------------------------------------
`define AST_OVS_LAST      4'hF
`define AST_STOP_T_HALF   6'h07
`define AST_STOP_T_1      6'h0F
`define AST_STOP_T_1P5    6'h17
`define AST_STOP_T_2      6'h1F
`define AST_SMP_FIRST     5'h02
`define AST_SMP_A         5'h03
`define AST_SMP_B         5'h05
`define AST_SMP_C         5'h07
`define AST_SMP_D         5'h08
`define AST_SMP_E         5'h09
`define AST_SMP_F         5'h0A
`define AST_SMP_LAST      5'h10

`endif

// ===== ast_baud.v
// shared baud generator: one oversample tick enable per divider period
module ast_baud #(
  parameter W = 16
) (
  input  wire         clk_in,
  input  wire         sys_rst_in,
  input  wire         run_in,
  input  wire [W-1:0] div_in,
  output reg          tick_out
);

  reg  [W-1:0] cnt_q;
  wire [W-1:0] div_m1;
  wire         last;

  assign div_m1 = div_in - {{(W-1){1'b0}}, 1'b1};
  // a divider of zero behaves like one, so the tick never dies
  assign last   = (cnt_q == div_m1) || (div_in == {W{1'b0}});

  // counter stops and rewinds while neither direction runs
  always @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      cnt_q    <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (last) begin
      cnt_q    <= {W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end

endmodule

// ===== ast_vote3.v
// three-sample majority with a disagreement flag
module ast_vote3 (
  input  wire [2:0] smp_in,
  output wire       val_out,
  output wire       noisy_out
);

  // majority picks the bit; any disagreement counts as noise
  assign val_out   = (smp_in[0] & smp_in[1]) | (smp_in[0] & smp_in[2]) | (smp_in[1] & smp_in[2]);
  assign noisy_out = (smp_in != 3'h0) && (smp_in != 3'h7);

endmodule

// ===== ast_uart_core_props.sv
// concurrent checks on the serial core ports
`include "ast_uart_map.vh"
module ast_uart_core_props (
  input wire logic                   clk_in,
  input wire logic                   sys_rst_in,
  input wire logic [`AST_ADDR_W-1:0] addr_in,
  input wire logic [15:0]            wr_data_in,
  input wire logic                   wr_in,
  input wire logic                   rd_in,
  input wire logic [15:0]            rd_data_out,
  input wire logic                   rx_line_in,
  input wire logic                   tx_line_out,
  input wire logic                   tx_line_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       en_q;  // shadow of unit_on and tx_path_on
  logic [8:0] low_q; // cycles the line has stayed low
  // helper state; a low run longer than a break means a stuck line
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_q  <= 1'b0;
      low_q <= 9'h000;
    end else begin
      if (wr_in && addr_in == `AST_OFS_CTRL1) en_q <= wr_data_in[`AST_CR1_UE] & wr_data_in[`AST_CR1_TE];
      low_q <= tx_line_out ? 9'h000 : low_q + 9'h001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_oe_track; tx_line_oe_out == $past(en_q); endproperty
  a_oe_track: assert property (p_oe_track) else $error("drive enable wrong");
  property p_low_bit; $fell(tx_line_out) && tx_line_oe_out |-> (!tx_line_out)[*8] ##1 (!tx_line_out)[*8]; endproperty
  a_low_bit: assert property (p_low_bit) else $error("low bit too short");
  property p_high_min; $rose(tx_line_out) && tx_line_oe_out |-> tx_line_out[*8]; endproperty
  a_high_min: assert property (p_high_min) else $error("high bit too short");
  property p_idle_first; $rose(tx_line_oe_out) |-> tx_line_out[*8] ##1 tx_line_out[*8]; endproperty
  a_idle_first: assert property (p_idle_first) else $error("no idle frame");
  property p_off_high; !tx_line_oe_out && !$past(tx_line_oe_out) |-> tx_line_out; endproperty
  a_off_high: assert property (p_off_high) else $error("line low while off");
  property p_rst; $past(sys_rst_in) |-> tx_line_out && !tx_line_oe_out && rd_data_out == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_data_w; rd_in && addr_in == `AST_OFS_DATA |=> rd_data_out[15:9] == 7'h00; endproperty
  a_data_w: assert property (p_data_w) else $error("data wider than 9 bits");
  property p_stat; rd_in && addr_in == `AST_OFS_STATUS |=> rd_data_out[15:8] == 8'h00; endproperty
  a_stat: assert property (p_stat) else $error("status upper bits set");
  property p_brk_max; low_q <= 9'h0B0; endproperty
  a_brk_max: assert property (p_brk_max) else $error("low run too long");
  c_break: cover property (low_q == 9'h0A0);
  c_enable: cover property ($rose(tx_line_oe_out));
  c_status: cover property (rd_in && addr_in == `AST_OFS_STATUS);
endmodule
bind ast_uart_core ast_uart_core_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .rx_line_in(rx_line_in),
  .tx_line_out(tx_line_out), .tx_line_oe_out(tx_line_oe_out));

// ===== ast_serial_peer.sv
// far-end serial equipment driving the receive line
module ast_serial_peer #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1; // pulled-up idle line
  // mode 0 clean, 1 glitch inside the start bit, 2 runt start; gap adds idle cycles before the start bit
  task automatic send(input logic [8:0] d, input logic nine, input int mode, input int gap);
    repeat (gap) @(posedge clk_in);
    line_out <= 1'b0;
    repeat (mode == 2 ? 6 : 2) @(posedge clk_in);
    line_out <= mode == 0 ? 1'b0 : 1'b1;
    repeat (2) @(posedge clk_in);
    line_out <= mode == 2 ? 1'b1 : 1'b0;
    repeat (BIT_CYC - 4) @(posedge clk_in);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      line_out <= mode == 2 ? 1'b1 : d[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (BIT_CYC + 4) @(posedge clk_in);
  endtask
endmodule

// ===== async_serial_tx_rx_core_test.sv
// self-checking bench for the serial core
`include "ast_uart_map.vh"
module async_serial_tx_rx_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, rd_seen = 1'b0, nine = 1'b0;
  logic [2:0]  addr_in = 3'h0;
  logic [15:0] wr_data_in = 16'h0000, rd_data_out, v;
  logic        tx_line_out, tx_line_oe_out, rx_line_in;
  logic [15:0] rd_exp[$];
  logic [9:0]  tx_exp[$], fr;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  always #12.5 clk_in = ~clk_in;
  ast_uart_core #(.BAUD_W(16)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .rx_line_in(rx_line_in),
    .tx_line_out(tx_line_out), .tx_line_oe_out(tx_line_oe_out));
  ast_serial_peer #(.BIT_CYC(16)) peer (.clk_in(clk_in), .line_out(rx_line_in));
  // ----
  // tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one strobe cycle; the next access waits an edge so no signal is driven twice at once
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    rd_exp.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask
  // frame image is stop slot above the data bits; a break has its stop slot low
  task automatic tx(input logic [8:0] d, input logic brk);
    tx_exp.push_back(nine ? {!brk, d} : {1'b0, !brk, d[7:0]});
    if (brk) bus(1'b1, `AST_OFS_CTRL1, nine ? 16'h300D : 16'h200D);
    else bus(1'b1, `AST_OFS_DATA, {7'h00, d});
  endtask
  // ----
  // monitors: read data one cycle after the strobe, transmit frames sampled mid-bit
  // ----
  always @(posedge clk_in) begin
    if (rd_seen) check(rd_data_out, rd_exp.pop_front());
    rd_seen <= rd_in;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      results();
    end
  end
  always begin
    @(negedge tx_line_out iff tx_line_oe_out);
    repeat (8) @(posedge clk_in);
    for (int i = 0; i <= (nine ? 9 : 8); i++) begin
      repeat (16) @(posedge clk_in);
      fr[i] = tx_line_out;
      if (!tx_line_oe_out) fr = 10'h3FF;
    end
    if (!nine) fr[9] = 1'b0;
    if (fr !== 10'h3FF) check({6'h00, fr}, tx_exp.size() ? {6'h00, tx_exp.pop_front()} : 16'hFFFF);
  end
  // ----
  // main sequence
  // ----
  initial begin
    v = $urandom(40486);
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(`AST_OFS_CTRL2, 16'h0000);
    rd(`AST_OFS_BAUD, `AST_BAUD_RST);
    bus(1'b1, 3'h5, 16'hFFFF);
    rd(3'h5, 16'h0000);
    bus(1'b1, `AST_OFS_BAUD, 16'h0001);
    bus(1'b1, `AST_OFS_CTRL1, 16'h200C);
    repeat (170) @(posedge clk_in);
    rd(`AST_OFS_STATUS, 16'h00C0);
    tx($urandom, 1'b0);
    rd(`AST_OFS_STATUS, 16'h0080);
    tx($urandom, 1'b0);
    rd(`AST_OFS_STATUS, 16'h0000);
    repeat (360) @(posedge clk_in);
    rd(`AST_OFS_STATUS, 16'h00C0);
    bus(1'b1, `AST_OFS_STATUS, 16'h0000);
    rd(`AST_OFS_STATUS, 16'h0080);
    tx(9'h000, 1'b1);
    repeat (200) @(posedge clk_in);
    rd(`AST_OFS_CTRL1, 16'h200C);
    tx($urandom, 1'b0);
    bus(1'b1, `AST_OFS_CTRL1, 16'h200D);
    bus(1'b1, `AST_OFS_CTRL1, 16'h200C);
    repeat (200) @(posedge clk_in);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `AST_OFS_CTRL2, 16'(c) << 12);
      rd(`AST_OFS_CTRL2, 16'(c) << 12);
      rd(`AST_OFS_STATUS, 16'h00C0);
      tx($urandom, 1'b0);
      // finished rises 144 cycles plus the stop length after the write edge
      repeat (142 + 8 * (c == 1 ? 1 : c == 0 ? 2 : c == 2 ? 4 : 3)) @(posedge clk_in);
      rd(`AST_OFS_STATUS, 16'h0080);
      rd(`AST_OFS_STATUS, 16'h00C0);
      repeat (20) @(posedge clk_in);
    end
    bus(1'b1, `AST_OFS_DATA, 16'h00FF);
    repeat (60) @(posedge clk_in);
    bus(1'b1, `AST_OFS_CTRL1, 16'h2004);
    bus(1'b1, `AST_OFS_CTRL1, 16'h300C);
    nine = 1'b1;
    repeat (190) @(posedge clk_in);
    tx($urandom, 1'b0);
    repeat (200) @(posedge clk_in);
    tx(9'h000, 1'b1);
    v = $urandom;
    peer.send(v[8:0], 1'b1, 0, 40);
    rd(`AST_OFS_DATA, {7'h00, v[8:0]});
    rd(`AST_OFS_STATUS, 16'h00C0);
    bus(1'b1, `AST_OFS_CTRL1, 16'h200C);
    nine = 1'b0;
    repeat (170) @(posedge clk_in);
    bus(1'b1, `AST_OFS_STATUS, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      v = $urandom;
      peer.send(v[8:0], 1'b0, m, 0);
      rd(`AST_OFS_STATUS, m == 2 ? 16'h0080 : m == 1 ? 16'h00A4 : 16'h00A0);
      if (m < 2) rd(`AST_OFS_DATA, {8'h00, v[7:0]});
      rd(`AST_OFS_STATUS, 16'h0080);
    end
    peer.send(9'h05A, 1'b0, 0, 0);
    peer.send(9'h0A5, 1'b0, 0, 0);
    rd(`AST_OFS_STATUS, 16'h00A8);
    rd(`AST_OFS_DATA, 16'h005A);
    peer.send(9'h033, 1'b0, 0, 0);
    bus(1'b1, `AST_OFS_STATUS, 16'h00C0);
    rd(`AST_OFS_STATUS, 16'h0080);
    fork
      peer.send(9'h0FF, 1'b0, 0, 0);
      begin
        repeat (60) @(posedge clk_in);
        bus(1'b1, `AST_OFS_CTRL1, 16'h2008);
        bus(1'b1, `AST_OFS_CTRL1, 16'h200C);
      end
    join
    rd(`AST_OFS_STATUS, 16'h0080);
    repeat (4) @(posedge clk_in);
    check(16'(tx_exp.size()), 16'h0000);
    results();
  end
endmodule
